/* File: shared/ctrl_port_pkg.sv */
// Constants for the indirect control-access front end.
// Assumes one system clock; all host requests are synchronous to it.
package ctrl_port_pkg;
  // Widths of the external and internal sides
  localparam int SEL_W = 3;
  localparam int BYTE_W = 8;
  localparam int IADDR_W = 10;
  localparam int IDATA_W = 36;
  localparam int NIB_W = 4;
  // External select codes
  localparam logic [2:0] SEL_DATA0 = 3'h0;
  localparam logic [2:0] SEL_DATA4 = 3'h4;
  localparam logic [2:0] SEL_RSVD = 3'h5;
  localparam logic [2:0] SEL_LOW_ADDR = 3'h6;
  localparam logic [2:0] SEL_ADDR_MODE = 3'h7;
  // Address mode register fields
  localparam int AMR_HI_LSB = 0;
  localparam int AMR_RD_INC = 6;
  localparam int AMR_WR_INC = 7;
  localparam logic [7:0] AMR_KEEP_MASK = 8'hc3;
  // Internal locations watched by this block
  localparam logic [9:0] MODE_ADDR = 10'h300;
  localparam logic [9:0] TUNING_ADDR = 10'h303;
  localparam logic [9:0] CIC2_SCALE_ADDR = 10'h305;
  localparam logic [9:0] CIC5_SCALE_ADDR = 10'h307;
  localparam logic [9:0] OUT_CTRL_ADDR = 10'h309;
  localparam logic [9:0] FILTER_TOP_ADDR = 10'h1ff;
  // Mode control register fields and reset value
  localparam int MODE_IDLE_BIT = 0;
  localparam int MODE_MASTER_BIT = 3;
  localparam logic [7:0] MODE_RESET = 8'h01;
  // Scaling field widths, each step is one 6 dB shift
  localparam int GAIN_STEP_DB = 6;
  localparam int CIC2_SHIFT_W = 3;
  localparam int CIC5_SHIFT_W = 5;
  localparam int OUT_SHIFT_W = 3;
  // Reset pulse minimum, rounded up to whole clocks
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 30;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: shared/addr_ptr_if.sv */
// Carrier between the access front end and its address pointer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface addr_ptr_if;
  logic ld_low; // Load low address byte
  logic ld_mode; // Load address mode byte
  logic [7:0] ld_val; // Byte to load
  logic step_rd; // An internal read was issued
  logic step_wr; // An internal write was issued
  logic [9:0] addr; // Current internal address
  logic [7:0] mode_bits; // Address mode readback
  logic [7:0] low_bits; // Low address readback
  // Pointer side
  modport owner (input ld_low, ld_mode, ld_val, step_rd, step_wr,
    output addr, mode_bits, low_bits);
  // Front end side
  modport user (output ld_low, ld_mode, ld_val, step_rd, step_wr,
    input addr, mode_bits, low_bits);
endinterface
`default_nettype wire

/* File: src/addr_pointer.sv */
// Internal address pointer: low address and address mode registers.
// Assumes the front end loads or steps it at most once per cycle.
`timescale 1ns/10ps
`default_nettype none
module addr_pointer
  import ctrl_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Front end link
  addr_ptr_if.owner ptr
);
  logic [7:0] low_addr_reg_ff; // Address bits 7:0
  logic [7:0] addr_mode_reg_ff; // Increment enables and address bits 9:8

  // Low byte: host load or auto-increment carry
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      low_addr_reg_ff <= 8'h00;
    else if (ptr.ld_low)
      low_addr_reg_ff <= ptr.ld_val;
    else if ((ptr.step_rd && addr_mode_reg_ff[AMR_RD_INC]) ||
             (ptr.step_wr && addr_mode_reg_ff[AMR_WR_INC]))
      low_addr_reg_ff <= low_addr_reg_ff + 8'h01;
  end

  // Mode byte: reserved bits stay zero, top address bits carry on wrap
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      addr_mode_reg_ff <= 8'h00;
    else if (ptr.ld_mode)
      addr_mode_reg_ff <= ptr.ld_val & AMR_KEEP_MASK;
    else if (((ptr.step_rd && addr_mode_reg_ff[AMR_RD_INC]) ||
              (ptr.step_wr && addr_mode_reg_ff[AMR_WR_INC])) && (low_addr_reg_ff == 8'hff))
      addr_mode_reg_ff[1:0] <= addr_mode_reg_ff[1:0] + 2'h1;
  end

  // Address persists until reloaded or stepped
  assign ptr.addr = {addr_mode_reg_ff[1:0], low_addr_reg_ff};
  assign ptr.mode_bits = addr_mode_reg_ff;
  assign ptr.low_bits = low_addr_reg_ff;

  // Stepping with the matching enable moves exactly one location
  chk_auto_inc_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ((ptr.step_wr && addr_mode_reg_ff[AMR_WR_INC]) ||
     (ptr.step_rd && addr_mode_reg_ff[AMR_RD_INC])) && !ptr.ld_low && !ptr.ld_mode
    |=> ptr.addr == $past(ptr.addr) + 10'h001)
    else $error("address did not step by one");
  // No load and no enabled step keeps the address
  chk_addr_persists: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ptr.ld_low && !ptr.ld_mode && !(ptr.step_wr && addr_mode_reg_ff[AMR_WR_INC]) &&
    !(ptr.step_rd && addr_mode_reg_ff[AMR_RD_INC]) |=> $stable(ptr.addr))
    else $error("address changed without cause");
endmodule
`default_nettype wire

/* File: src/indirect_control_access_port.sv */
// Indirect control-access front end: staged byte registers to a 10-bit space.
// Assumes host strobes and internal bus are synchronous to sys_clk;
// internal read data is valid one cycle after int_rd.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Pin reset clears filter and oscillator accumulators
// - After reset, held idle with mode bit 0
// - Held idle: ignore input samples, no processing
// - Held idle: outputs inactive, sync pins input
// - First output sample after start is zero
// - Reset leaves data RAMs; host may zero them
// - Writing 0x300 bit 0 low starts processing
// - Listed registers may be rewritten while running
// - Scaling registers adjust gain in 6 dB steps
// - Tuning read as master pulses oscillator align
// - Three-bit select and eight-bit data access
// - Select codes map data, low address, mode
// - Ten-bit address from low and mode registers
// - Mode register: address bits, increment enables
// - Only low nibble of top data register used
// - Write of byte 0 pushes all data
// - Read of byte 0 fetches upper bytes
// - Increment setting: hold, reads, writes, both
// - Mode bit 3 selects sync master, outputs
module indirect_control_access_port
  import ctrl_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Host register port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [SEL_W-1:0] host_sel,
  input wire logic [BYTE_W-1:0] host_wdata,
  output logic [BYTE_W-1:0] host_rdata,
  output logic host_ack,
  output logic host_busy,
  // Internal register space
  output logic [IADDR_W-1:0] int_addr,
  output logic [IDATA_W-1:0] int_wdata,
  output logic int_wr,
  output logic int_rd,
  input wire logic [IDATA_W-1:0] int_rdata,
  // Datapath control
  input wire logic out_sample_stb,
  output logic acc_clear,
  output logic input_accept,
  output logic proc_run,
  output logic serial_out_en,
  output logic par_out_en,
  output logic zero_next_sample,
  output logic osc_align_pulse,
  // Sync pin, output side
  output logic sync_pin_out,
  output logic sync_pin_oe,
  // Gain shifts, one count per 6 dB
  output logic [CIC2_SHIFT_W-1:0] cic2_shift,
  output logic [CIC5_SHIFT_W-1:0] cic5_shift,
  output logic [OUT_SHIFT_W-1:0] out_shift
);
  // Access sequencer states
  typedef enum logic [1:0] {ST_READY, ST_RD_WAIT, ST_RD_LOAD} acc_state_t;

  acc_state_t st_ff; // Sequencer state
  logic [7:0] data_byte_ff [4]; // Data byte registers 0..3
  logic [NIB_W-1:0] data_top_nibble_reg_ff; // Data register 4, low nibble only
  logic [7:0] mode_ctrl_ff; // Mode control register at 0x300
  logic [BYTE_W-1:0] host_rdata_ff; // Host read return
  logic host_ack_ff; // Host answer pulse
  logic host_busy_ff; // Byte 0 read in progress
  logic [IADDR_W-1:0] int_addr_ff; // Latched internal address
  logic [IDATA_W-1:0] int_wdata_ff; // Pushed data word
  logic int_wr_ff; // Internal write pulse
  logic int_rd_ff; // Internal read pulse
  logic acc_clear_ff; // Accumulator clear
  logic input_accept_ff; // Input port open
  logic proc_run_ff; // Processing running
  logic serial_out_en_ff; // Serial output active
  logic par_out_en_ff; // Parallel output active
  logic zero_next_ff; // Force next sample to zero
  logic osc_align_ff; // Oscillator align pulse
  logic sync_oe_ff; // Sync pin driven
  logic [CIC2_SHIFT_W-1:0] cic2_shift_ff; // Shadow of 0x305 shift
  logic [CIC5_SHIFT_W-1:0] cic5_shift_ff; // Shadow of 0x307 shift
  logic [OUT_SHIFT_W-1:0] out_shift_ff; // Shadow of 0x309 shift
  logic take_wr; // Write taken this cycle
  logic take_rd; // Read taken this cycle
  logic push_wr; // Byte 0 write pushes a word
  logic fetch_rd; // Byte 0 read fetches a word
  logic [IDATA_W-1:0] staged_word; // Staged data as one word
  logic [IDATA_W-1:0] fetched_word; // Read return, local or internal
  logic held_idle; // Mode bit 0

  addr_ptr_if ptr (); // Address pointer link

  // Address pointer instance
  addr_pointer u_ptr (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .ptr (ptr)
  );

  // Requests are taken only while ready; write wins a tie
  assign take_wr = (st_ff == ST_READY) && host_wr;
  assign take_rd = (st_ff == ST_READY) && host_rd && !host_wr;
  assign push_wr = take_wr && (host_sel == SEL_DATA0);
  assign fetch_rd = take_rd && (host_sel == SEL_DATA0);
  assign held_idle = mode_ctrl_ff[MODE_IDLE_BIT];
  assign staged_word = {data_top_nibble_reg_ff, data_byte_ff[3], data_byte_ff[2],
                        data_byte_ff[1], host_wdata};
  // Mode register is held here, the rest comes from the internal space
  assign fetched_word = (int_addr_ff == MODE_ADDR) ? {28'h0000000, mode_ctrl_ff} : int_rdata;

  // Pointer loads and steps
  assign ptr.ld_low = take_wr && (host_sel == SEL_LOW_ADDR);
  assign ptr.ld_mode = take_wr && (host_sel == SEL_ADDR_MODE);
  assign ptr.ld_val = host_wdata;
  assign ptr.step_wr = push_wr;
  assign ptr.step_rd = fetch_rd;

  // Access sequencer: a byte 0 read waits for internal data
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= ST_READY;
    else
    begin
      unique case (st_ff)
        ST_READY:
        begin
          if (fetch_rd)
            st_ff <= ST_RD_WAIT;
        end
        ST_RD_WAIT:
          st_ff <= ST_RD_LOAD;
        ST_RD_LOAD:
          st_ff <= ST_READY;
      endcase
    end
  end

  // Data byte registers 0..3, written by host or loaded by a fetch
  for (genvar gi = 0; gi < 4; gi++)
  begin : g_byte
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        data_byte_ff[gi] <= 8'h00;
      else if (st_ff == ST_RD_LOAD)
        data_byte_ff[gi] <= fetched_word[gi*8 +: 8];
      else if (take_wr && (host_sel == SEL_W'(gi)))
        data_byte_ff[gi] <= host_wdata;
    end
  end

  // Data register 4 keeps only its low nibble
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_top_nibble_reg_ff <= 4'h0;
    else if (st_ff == ST_RD_LOAD)
      data_top_nibble_reg_ff <= fetched_word[IDATA_W-1 -: NIB_W];
    else if (take_wr && (host_sel == SEL_DATA4))
      data_top_nibble_reg_ff <= host_wdata[NIB_W-1:0];
  end

  // Host read return and answer; reserved code reads zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_rdata_ff <= 8'h00;
      host_ack_ff <= 1'b0;
    end
    else if (st_ff == ST_RD_LOAD)
    begin
      host_rdata_ff <= fetched_word[7:0];
      host_ack_ff <= 1'b1;
    end
    else if (take_rd && !fetch_rd)
    begin
      host_ack_ff <= 1'b1;
      unique case (host_sel)
        SEL_DATA4: host_rdata_ff <= {4'h0, data_top_nibble_reg_ff};
        SEL_RSVD: host_rdata_ff <= 8'h00;
        SEL_LOW_ADDR: host_rdata_ff <= ptr.low_bits;
        SEL_ADDR_MODE: host_rdata_ff <= ptr.mode_bits;
        default: host_rdata_ff <= data_byte_ff[host_sel[1:0]];
      endcase
    end
    else
      host_ack_ff <= take_wr;
  end

  // Internal access pulses with address taken from the pointer
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      int_addr_ff <= 10'h000;
      int_wdata_ff <= 36'h000000000;
      int_wr_ff <= 1'b0;
      int_rd_ff <= 1'b0;
      host_busy_ff <= 1'b0;
    end
    else
    begin
      host_busy_ff <= fetch_rd || (st_ff == ST_RD_WAIT);
      int_wr_ff <= push_wr;
      int_rd_ff <= fetch_rd;
      if (push_wr || fetch_rd)
        int_addr_ff <= ptr.addr;
      if (push_wr)
        int_wdata_ff <= staged_word;
    end
  end

  // Mode control: resets into held idle; any write is taken as is
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_ctrl_ff <= MODE_RESET;
    else if (push_wr && (ptr.addr == MODE_ADDR))
      mode_ctrl_ff <= host_wdata;
  end

  // Gain shadows, writable while running like other dynamic registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cic2_shift_ff <= 3'h0;
      cic5_shift_ff <= 5'h00;
      out_shift_ff <= 3'h0;
    end
    else if (push_wr)
    begin
      unique case (ptr.addr)
        CIC2_SCALE_ADDR: cic2_shift_ff <= host_wdata[CIC2_SHIFT_W-1:0];
        CIC5_SCALE_ADDR: cic5_shift_ff <= host_wdata[CIC5_SHIFT_W-1:0];
        OUT_CTRL_ADDR: out_shift_ff <= host_wdata[OUT_SHIFT_W-1:0];
        default: ;
      endcase
    end
  end

  // Accumulator clear held through reset, dropped on first edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      acc_clear_ff <= 1'b1;
    else
      acc_clear_ff <= 1'b0;
  end

  // Datapath gates follow the idle bit; ports quiet while idle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      input_accept_ff <= 1'b0;
      proc_run_ff <= 1'b0;
      serial_out_en_ff <= 1'b0;
      par_out_en_ff <= 1'b0;
      sync_oe_ff <= 1'b0;
    end
    else
    begin
      input_accept_ff <= !held_idle;
      proc_run_ff <= !held_idle;
      serial_out_en_ff <= !held_idle;
      par_out_en_ff <= !held_idle;
      sync_oe_ff <= !held_idle && mode_ctrl_ff[MODE_MASTER_BIT];
    end
  end

  // First sample after leaving idle is forced to zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      zero_next_ff <= 1'b1;
    else if (held_idle)
      zero_next_ff <= 1'b1;
    else if (out_sample_stb)
      zero_next_ff <= 1'b0;
  end

  // Tuning read as master realigns the oscillator; as slave it does not
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      osc_align_ff <= 1'b0;
    else
      osc_align_ff <= (st_ff == ST_RD_WAIT) && (int_addr_ff == TUNING_ADDR) &&
                      mode_ctrl_ff[MODE_MASTER_BIT];
  end

  // Outputs straight from flip-flops
  assign host_rdata = host_rdata_ff;
  assign host_ack = host_ack_ff;
  assign host_busy = host_busy_ff;
  assign int_addr = int_addr_ff;
  assign int_wdata = int_wdata_ff;
  assign int_wr = int_wr_ff;
  assign int_rd = int_rd_ff;
  assign acc_clear = acc_clear_ff;
  assign input_accept = input_accept_ff;
  assign proc_run = proc_run_ff;
  assign serial_out_en = serial_out_en_ff;
  assign par_out_en = par_out_en_ff;
  assign zero_next_sample = zero_next_ff;
  assign osc_align_pulse = osc_align_ff;
  assign sync_pin_out = osc_align_ff;
  assign sync_pin_oe = sync_oe_ff;
  assign cic2_shift = cic2_shift_ff;
  assign cic5_shift = cic5_shift_ff;
  assign out_shift = out_shift_ff;

  // Byte 0 read: issue, wait, then answer with the low byte
  sequence seq_fetch_issue;
    int_rd_ff ##1 !int_rd_ff;
  endsequence
  sequence seq_fetch_answer;
    !host_ack_ff ##2 host_ack_ff && host_rdata_ff == data_byte_ff[0];
  endsequence

  chk_fetch_sequence: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fetch_rd |=> seq_fetch_issue and seq_fetch_answer)
    else $error("byte 0 read did not fetch and answer in three cycles");
  chk_push_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
    push_wr |=> int_wr_ff && int_wdata_ff[7:0] == $past(host_wdata) &&
    int_wdata_ff[15:8] == data_byte_ff[1])
    else $error("byte 0 write did not push staged word");
  chk_idle_input_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    held_idle && $past(held_idle) |-> !input_accept_ff && !proc_run_ff)
    else $error("input open while held idle");
  chk_idle_ports_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    held_idle |=> !serial_out_en_ff && !par_out_en_ff && !sync_oe_ff)
    else $error("outputs active while held idle");
  chk_master_sync_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !held_idle && mode_ctrl_ff[MODE_MASTER_BIT] |=> sync_oe_ff)
    else $error("master did not drive sync pin");
  chk_tuning_align: assert property (@(posedge sys_clk) disable iff (!rst_b)
    fetch_rd && ptr.addr == TUNING_ADDR |-> ##2
    (osc_align_ff == $past(mode_ctrl_ff[MODE_MASTER_BIT], 1)))
    else $error("tuning read align pulse wrong for sync role");
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_rd && host_sel == SEL_RSVD |=> host_ack_ff && host_rdata_ff == 8'h00)
    else $error("reserved select did not read zero");
  chk_start_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(held_idle) |-> zero_next_ff)
    else $error("first sample not forced to zero");
  chk_nibble_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_rd && host_sel == SEL_DATA4 |=> host_rdata_ff[7:4] == 4'h0)
    else $error("top data register upper nibble not zero");
endmodule
`default_nettype wire

/* File: sim/int_space_model.sv */
// Model of the internal register space behind the access port.
// Assumes int_wr and int_rd are one-cycle pulses on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module int_space_model
  import ctrl_port_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Internal bus
  input wire logic [IADDR_W-1:0] int_addr,
  input wire logic [IDATA_W-1:0] int_wdata,
  input wire logic int_wr,
  input wire logic int_rd,
  output logic [IDATA_W-1:0] int_rdata
);
  // Word store, never cleared by the pin reset
  logic [IDATA_W-1:0] mem [0:1023];
  initial
  begin
    foreach (mem[i])
      mem[i] = '0;
    int_rdata = '0;
  end
  // Take pushed words
  always @(posedge sys_clk)
  begin
    if (int_wr)
      mem[int_addr] <= int_wdata;
  end
  // Data valid one cycle after the read, churning otherwise
  always @(posedge sys_clk)
  begin
    if (int_rd)
      int_rdata <= mem[int_addr];
    else
      int_rdata <= ~int_rdata;
  end
endmodule
`default_nettype wire

/* File: sim/indirect_control_access_port_tb.sv */
// Self-checking bench for the indirect control-access front end.
// Assumes the internal space model answers one cycle after int_rd.
`timescale 1ns/10ps
`default_nettype none
module indirect_control_access_port_tb
  import ctrl_port_pkg::*;
;
  // Driven inputs
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [SEL_W-1:0] host_sel = '0;
  logic [BYTE_W-1:0] host_wdata = '0;
  logic out_sample_stb = 1'b0;
  // Design outputs
  logic [BYTE_W-1:0] host_rdata;
  logic host_ack, host_busy, int_wr, int_rd, acc_clear, input_accept, proc_run;
  logic serial_out_en, par_out_en, zero_next_sample, osc_align_pulse;
  logic sync_pin_out, sync_pin_oe;
  logic [IADDR_W-1:0] int_addr;
  logic [IDATA_W-1:0] int_wdata, int_rdata;
  logic [CIC2_SHIFT_W-1:0] cic2_shift;
  logic [CIC5_SHIFT_W-1:0] cic5_shift;
  logic [OUT_SHIFT_W-1:0] out_shift;
  // Bookkeeping
  int err_total = 0;
  int checked = 0;
  int n_wr = 0;
  int n_align = 0;
  int k;
  logic [IADDR_W-1:0] wr_addr;
  logic [IDATA_W-1:0] wr_data, word;
  logic [7:0] b;
  logic [1:0] inc;
  // Register rows: select, written byte, byte read back
  typedef struct packed {logic [2:0] sel; logic [7:0] wd; logic [7:0] ex;} row_t;
  row_t rows [8] = '{'{3'h1, 8'h3c, 8'h3c}, '{3'h2, 8'hc3, 8'hc3},
    '{3'h3, 8'h81, 8'h81}, '{3'h4, 8'hff, 8'h0f}, '{3'h5, 8'h5a, 8'h00},
    '{3'h6, 8'ha5, 8'ha5}, '{3'h7, 8'hff, 8'hc3}, '{3'h7, 8'h00, 8'h00}};
  // Clock, 40 ns
  always #20 sys_clk = ~sys_clk;
  // Designs under test
  indirect_control_access_port i_indirect_control_access_port (.sys_clk, .rst_b,
    .host_wr, .host_rd, .host_sel, .host_wdata, .host_rdata, .host_ack,
    .host_busy, .int_addr, .int_wdata, .int_wr, .int_rd, .int_rdata,
    .out_sample_stb, .acc_clear, .input_accept, .proc_run, .serial_out_en,
    .par_out_en, .zero_next_sample, .osc_align_pulse, .sync_pin_out,
    .sync_pin_oe, .cic2_shift, .cic5_shift, .out_shift);
  int_space_model i_int_space_model (.sys_clk, .int_addr, .int_wdata, .int_wr,
    .int_rd, .int_rdata);
  // Count internal writes and align pulses
  always @(posedge sys_clk)
  begin
    if (int_wr === 1'b1)
    begin
      n_wr <= n_wr + 1;
      wr_addr <= int_addr;
      wr_data <= int_wdata;
    end
    if (osc_align_pulse === 1'b1 && sync_pin_out === 1'b1)
      n_align <= n_align + 1;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One host access, held until acknowledged
  task automatic acc(input logic wr, input logic [2:0] sel, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    @(negedge sys_clk);
    host_wr = wr;
    host_rd = !wr;
    host_sel = sel;
    host_wdata = wd;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
      if (n == 1)
        chk("busy", host_busy, !wr && sel == SEL_DATA0);
    end
    while (host_ack !== 1'b1 && n < 8);
    chk("ack delay", n, (!wr && sel == SEL_DATA0) ? 3 : 1);
    rd = host_rdata;
    host_wr = 1'b0;
    host_rd = 1'b0;
  endtask
  // Load pointer with increment enables
  task automatic set_addr(input logic [9:0] a, input logic [1:0] ie);
    logic [7:0] r;
    acc(1'b1, SEL_ADDR_MODE, {ie, 4'h0, a[9:8]}, r);
    acc(1'b1, SEL_LOW_ADDR, a[7:0], r);
  endtask
  // Push a word, top bytes first
  task automatic push(input logic [35:0] d);
    logic [39:0] w;
    logic [7:0] r;
    w = {4'h0, d};
    for (int i = 4; i >= 0; i--)
      acc(1'b1, 3'(i), w[8*i+:8], r);
  endtask
  // Fetch a word, byte 0 first
  task automatic fetch(output logic [35:0] d);
    logic [39:0] w;
    logic [7:0] r;
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b0, 3'(i), 8'h00, r);
      w[8*i+:8] = r;
    end
    d = w[35:0];
  endtask
  // Test end line
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  // Counts, verdict, stop
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    repeat (20) @(negedge sys_clk);
    chk("acc_clear", acc_clear, 1'b1);
    chk("zero_next", zero_next_sample, 1'b1);
    chk("idle outs", {proc_run, input_accept, serial_out_en, par_out_en, sync_pin_oe}, 5'h00);
    rst_b = 1'b1;
    @(negedge sys_clk);
    chk("acc_clear", acc_clear, 1'b0);
    set_addr(MODE_ADDR, 2'b00);
    fetch(word);
    chk("mode", word[7:0], MODE_RESET);
    done("reset");
    foreach (rows[i])
    begin
      acc(1'b1, rows[i].sel, rows[i].wd, b);
      acc(1'b0, rows[i].sel, 8'h00, b);
      chk("ext reg", b, rows[i].ex);
    end
    done("registers");
    set_addr(TUNING_ADDR, 2'b10);
    k = n_wr;
    push(36'h9cbefefff);
    @(negedge sys_clk);
    chk("push count", n_wr - k, 1);
    chk("push addr", wr_addr, TUNING_ADDR);
    chk("push data", wr_data, 36'h9cbefefff);
    acc(1'b0, SEL_LOW_ADDR, 8'h00, b);
    chk("write step", b, 8'h04);
    set_addr(TUNING_ADDR, 2'b00);
    k = n_align;
    fetch(word);
    chk("fetch", word, 36'h9cbefefff);
    chk("slave align", n_align - k, 0);
    acc(1'b0, SEL_LOW_ADDR, 8'h00, b);
    chk("held addr", b, 8'h03);
    done("word");
    for (int m = 0; m < 4; m++)
    begin
      inc = 2'(m);
      set_addr(10'h310, inc);
      push(36'h0);
      fetch(word);
      acc(1'b0, SEL_LOW_ADDR, 8'h00, b);
      chk("step mode", b, 8'h10 + inc[0] + inc[1]);
    end
    set_addr(10'h3ff, 2'b10);
    push(36'h0);
    acc(1'b0, SEL_ADDR_MODE, 8'h00, b);
    chk("wrap", b, 8'h80);
    done("increment");
    set_addr(MODE_ADDR, 2'b00);
    push(36'h9);
    repeat (2) @(negedge sys_clk);
    chk("still idle", {proc_run, sync_pin_oe}, 2'h0);
    push(36'h8);
    repeat (2) @(negedge sys_clk);
    chk("run outs", {proc_run, input_accept, serial_out_en, par_out_en, sync_pin_oe}, 5'h1f);
    chk("zero_next", zero_next_sample, 1'b1);
    out_sample_stb = 1'b1;
    @(negedge sys_clk);
    out_sample_stb = 1'b0;
    @(negedge sys_clk);
    chk("zero_next", zero_next_sample, 1'b0);
    set_addr(CIC2_SCALE_ADDR, 2'b00);
    push(36'h6);
    set_addr(CIC5_SCALE_ADDR, 2'b00);
    push(36'h14);
    set_addr(OUT_CTRL_ADDR, 2'b00);
    push(36'h4);
    repeat (2) @(negedge sys_clk);
    chk("shifts", {cic2_shift, cic5_shift, out_shift}, {3'h6, 5'h14, 3'h4});
    set_addr(TUNING_ADDR, 2'b00);
    k = n_align;
    fetch(word);
    chk("master align", n_align - k, 1);
    set_addr(MODE_ADDR, 2'b00);
    push(36'h0);
    repeat (2) @(negedge sys_clk);
    chk("slave oe", sync_pin_oe, 1'b0);
    set_addr(TUNING_ADDR, 2'b00);
    k = n_align;
    fetch(word);
    chk("slave align", n_align - k, 0);
    set_addr(MODE_ADDR, 2'b00);
    push(36'h1);
    repeat (2) @(negedge sys_clk);
    chk("idle again", proc_run, 1'b0);
    done("run");
    push(36'h8);
    rst_b = 1'b0;
    @(negedge sys_clk);
    chk("reset outs", {acc_clear, proc_run, sync_pin_oe}, 3'h4);
    rst_b = 1'b1;
    set_addr(MODE_ADDR, 2'b00);
    fetch(word);
    chk("mode", word[7:0], MODE_RESET);
    set_addr(TUNING_ADDR, 2'b00);
    fetch(word);
    chk("kept word", word, 36'h9cbefefff);
    done("second reset");
    give_verdict;
  end
endmodule
`default_nettype wire
